/* src/sbs_defs.svh */
// Offsets, field positions, reset values and timing counts of the sync/error/power block.
// Assumes mclk at 125 MHz; counts are derived from the period below.
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

`define SBS_CLK_NS 8
`define SBS_CYC_UP(ns) (((ns) + `SBS_CLK_NS - 1) / `SBS_CLK_NS)
`define SBS_CYC_DN(ns) ((ns) / `SBS_CLK_NS)

// Register byte offsets
`define SBS_OFS_CTRL 8'h00
`define SBS_OFS_STATUS 8'h04
`define SBS_OFS_ENABLE 8'h08
`define SBS_OFS_BUFFLAG 8'h0C
`define SBS_OFS_BUFEN 8'h10
`define SBS_OFS_MODE 8'h14

// Control register fields
`define SBS_CTRL_MASTER 0
`define SBS_CTRL_ALARM 1
`define SBS_CTRL_SLEEP_REQUEST 2
`define SBS_CTRL_SOFTRST 3
`define SBS_CTRL_STOP_IN_CPU_WAIT 4
`define SBS_CTRL_SLEEP_ACKNOWLEDGE 5
`define SBS_CTRL_RESET 6'h00
`define SBS_CTRL_W 6

// Status and enable fields
`define SBS_ST_ALARM_SYNC 0
`define SBS_ST_NORMAL_SYNC 1
`define SBS_ST_FORMAT 2
`define SBS_ST_EARLY 3
`define SBS_ST_LOST 4
`define SBS_ST_BADPULSE 5
`define SBS_ST_WAKEUP 6
`define SBS_ST_OVERRUN 7
`define SBS_ST_LOCK 8
`define SBS_ST_SLOT 9
`define SBS_ST_FIFO 10
`define SBS_ST_W 10
`define SBS_EN_W 11

// Pulse lengths in ns
`define SBS_SYN_A_MIN_NS 1825
`define SBS_SYN_A_MAX_NS 2175
`define SBS_SYN_N_MIN_NS 2825
`define SBS_SYN_N_MAX_NS 3175
`define SBS_BIT_NS 100
// Cycle timing in ns, alarm hold in ms, echo and idle times in bits
`define SBS_CYC_NOM_NS 250000
`define SBS_CYC_MIN_NS 249700
`define SBS_CYC_MAX_NS 250300
`define SBS_ALARM_MS 255
`define SBS_ECHO_BITS 8
`define SBS_IDLE_BITS 11

`endif

/* src/sbs_pkg.sv */
// Types shared by the sync/error/power block.
// Assumes nothing beyond the defs header.
package sbs_pkg;
    typedef enum logic [2:0] {PLS_SHORT, PLS_ALARM, PLS_GAP, PLS_NORMAL, PLS_LONG} sbs_pulse_e;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_SOFTRST, MODE_PWRSAVE} sbs_mode_e;
endpackage

/* src/sbs_pulse_if.sv */
// Carrier between the sync engine and the dominant-pulse meter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sbs_pulse_if;
    import sbs_pkg::*;
    logic rxLevel;
    logic pulseEnd;
    logic [15:0] pulseLen;
    sbs_pulse_e pulseClass;
    modport meas (input rxLevel, output pulseEnd, output pulseLen, output pulseClass);
    modport core (output rxLevel, input pulseEnd, input pulseLen, input pulseClass);
endinterface
`default_nettype wire

/* src/sbs_pulse_meter.sv */
// Measures each dominant (low) pulse on the effective receive level and classifies it.
// Assumes rxLevel is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module sbs_pulse_meter
    import sbs_pkg::*;
#(
    parameter logic [15:0] A_MIN = 16'd229,
    parameter logic [15:0] A_MAX = 16'd271,
    parameter logic [15:0] N_MIN = 16'd354,
    parameter logic [15:0] N_MAX = 16'd396
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Pulse report
    sbs_pulse_if.meas pls
);
    logic prevLevel_reg;
    logic [15:0] lowCnt_reg;
    logic pulseEnd_reg;
    logic [15:0] pulseLen_reg;

    function automatic sbs_pulse_e classify(input logic [15:0] len);
        if (len < A_MIN)
            return PLS_SHORT;
        else if (len <= A_MAX)
            return PLS_ALARM;
        else if (len < N_MIN)
            return PLS_GAP;
        else if (len <= N_MAX)
            return PLS_NORMAL;
        else
            return PLS_LONG;
    endfunction

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            prevLevel_reg <= 1'b1;
            lowCnt_reg <= 16'h0000;
            pulseEnd_reg <= 1'b0;
            pulseLen_reg <= 16'h0000;
        end
        else
        begin
            prevLevel_reg <= pls.rxLevel;
            // Saturate so an endless dominant level still classifies as too long
            if (!pls.rxLevel && lowCnt_reg != 16'hFFFF)
                lowCnt_reg <= lowCnt_reg + 16'h0001;
            else if (pls.rxLevel)
                lowCnt_reg <= 16'h0000;
            pulseEnd_reg <= !prevLevel_reg && pls.rxLevel;
            if (!prevLevel_reg && pls.rxLevel)
                pulseLen_reg <= lowCnt_reg;
        end
    end

    assign pls.pulseEnd = pulseEnd_reg;
    assign pls.pulseLen = pulseLen_reg;
    assign pls.pulseClass = classify(pulseLen_reg);
endmodule
`default_nettype wire

/* src/sbs_sync_power.sv */
// Sync generation and checking, error flags, interrupt grouping and low-power control.
// Assumes an Avalon-MM master on mclk and an asynchronous bus receive pin.
//
// Behaviour
// - Master sends sync pulses, alarm type on request
// - Alarm bit self-clears after 255 to 256 ms
// - Format errors flagged, resume after idle time
// - Early valid sync still syncs, flags early
// - Missing sync flags lost, blocks transfers
// - Bad-length or late pulses flag, block transfers
// - Own transmit echoed to receive, plus eight bits
// - Sync only strictly inside alarm/normal windows
// - Pulse in wait time: restart or error
// - Valid length syncs at any position
// - Alarm and normal syncs have separate flags
// - Four interrupt request outputs
// - Each flag gated by enable; buffers split
// - Falling receive edge wakes, sets wake flag
// - Wake interrupt needs acknowledge and enable
// - Master resumes sync soon after wake
// - Clocks stop per sleep, reset, power-save
// - Mode follows stop, wait and control bits
// - Sleep waits for pending transmit or receive
// - Asleep: acknowledge set, transmit recessive
// - Bus activity, request clear or reset wake
// - Request clear ignored until acknowledged
// - After wake wait for sync before transfers; code waits only after a bus-activity wake
// - Soft reset halts transfers at once
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"
module sbs_sync_power
    import sbs_pkg::*;
#(
    parameter int unsigned CYC_NOM = `SBS_CYC_UP(`SBS_CYC_NOM_NS),
    parameter int unsigned CYC_MIN = `SBS_CYC_UP(`SBS_CYC_MIN_NS),
    parameter int unsigned CYC_MAX = `SBS_CYC_DN(`SBS_CYC_MAX_NS),
    parameter int unsigned ALARM_CYC = `SBS_CYC_UP(`SBS_ALARM_MS * 1000000),
    parameter int unsigned BIT_CYC = `SBS_CYC_UP(`SBS_BIT_NS)
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Bus transceiver
    input wire logic busRx,
    output logic busTx,
    // CPU state
    input wire logic cpuStopped,
    input wire logic cpuWaiting,
    // Message core
    input wire logic txCore,
    input wire logic txActive,
    input wire logic txPending,
    input wire logic rxBusy,
    input wire logic frameError,
    input wire logic fifoNotEmpty,
    input wire logic fifoOverrun,
    input wire logic lockError,
    input wire logic slotMismatch,
    input wire logic [15:0] bufSet,
    input wire logic [15:0] bufIsTx,
    output logic rxCore,
    output logic transferBlocked,
    output logic syncStrobe,
    // Clock control
    output logic coreClkRun,
    output logic regClkRun,
    // Interrupt requests
    output logic irqFifo,
    output logic irqRx,
    output logic irqSync,
    output logic irqGeneral
);
    localparam logic [15:0] A_MIN = 16'(`SBS_CYC_UP(`SBS_SYN_A_MIN_NS));
    localparam logic [15:0] A_MAX = 16'(`SBS_CYC_DN(`SBS_SYN_A_MAX_NS));
    localparam logic [15:0] N_MIN = 16'(`SBS_CYC_UP(`SBS_SYN_N_MIN_NS));
    localparam logic [15:0] N_MAX = 16'(`SBS_CYC_DN(`SBS_SYN_N_MAX_NS));
    localparam logic [15:0] A_NOM = 16'((32'(A_MIN) + 32'(A_MAX)) / 2);
    localparam logic [15:0] N_NOM = 16'((32'(N_MIN) + 32'(N_MAX)) / 2);
    localparam logic [15:0] CNOM = 16'(CYC_NOM);
    localparam logic [15:0] CMIN = 16'(CYC_MIN);
    localparam logic [15:0] CMAX = 16'(CYC_MAX);
    localparam logic [15:0] WAIT_END = 16'(CYC_MIN - 32'(N_MAX));
    localparam logic [7:0] ECHO_CYC = 8'(`SBS_ECHO_BITS * BIT_CYC);
    localparam logic [7:0] IDLE_CYC = 8'(`SBS_IDLE_BITS * BIT_CYC);
    localparam logic [24:0] ALARM_LAST = 25'(ALARM_CYC - 1);

    // Bus slave
    logic waitReq_reg;
    logic [31:0] rdData_reg;
    logic wrTake;
    logic [31:0] wdata;
    // Registers
    logic [`SBS_CTRL_W-1:0] ctrl_reg;
    logic [`SBS_ST_W-1:0] status_reg;
    logic [`SBS_EN_W-1:0] enable_reg;
    logic [15:0] bufFlag_reg;
    logic [15:0] bufEn_reg;
    logic [24:0] alarmCnt_reg;
    // Receive path
    logic rxMeta_reg;
    logic rxSync_reg;
    logic rxSyncPrev_reg;
    logic [7:0] echoCnt_reg;
    logic txNext;
    logic txBusy;
    logic rxEff;
    // Sync engine
    logic [15:0] cycCnt_reg;
    logic blocked_reg;
    logic [7:0] idleCnt_reg;
    logic masterDrive_reg;
    logic [15:0] masterCnt_reg;
    logic [15:0] masterLen;
    logic [15:0] startPos;
    logic inWait;
    logic validSync;
    logic earlyEvt;
    logic formatEvt;
    logic badEvt;
    logic lostEvt;
    logic wakeEvt;
    logic [`SBS_ST_W-1:0] setVec;
    logic [`SBS_ST_W-1:0] clrVec;
    // Mode
    sbs_mode_e mode;
    logic coreRun;
    logic sleepReadyNow;

    sbs_pulse_if pls();

    sbs_pulse_meter #(
        .A_MIN(A_MIN),
        .A_MAX(A_MAX),
        .N_MIN(N_MIN),
        .N_MAX(N_MAX)
    ) u_meter (
        .mclk(mclk),
        .reset(reset),
        .pls(pls.meas)
    );

    // Avalon handshake: one wait cycle, then the access completes
    assign wrTake = avs_write && !waitReq_reg;
    assign wdata = avs_writedata;

    always_ff @(posedge mclk)
    begin
        if (reset)
            waitReq_reg <= 1'b1;
        else if ((avs_read || avs_write) && waitReq_reg)
            waitReq_reg <= 1'b0;
        else
            waitReq_reg <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            rdData_reg <= 32'h0000_0000;
        else if (avs_read && waitReq_reg)
        begin
            unique case (avs_address)
                `SBS_OFS_CTRL: rdData_reg <= 32'(ctrl_reg);
                `SBS_OFS_STATUS: rdData_reg <= 32'({fifoNotEmpty, status_reg});
                `SBS_OFS_ENABLE: rdData_reg <= 32'(enable_reg);
                `SBS_OFS_BUFFLAG: rdData_reg <= 32'(bufFlag_reg);
                `SBS_OFS_BUFEN: rdData_reg <= 32'(bufEn_reg);
                `SBS_OFS_MODE: rdData_reg <= 32'(mode);
                default: rdData_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Mode selection; power save overrides the control bits
    always_comb
    begin
        if (cpuStopped || (cpuWaiting && ctrl_reg[`SBS_CTRL_STOP_IN_CPU_WAIT]))
            mode = MODE_PWRSAVE;
        else if (ctrl_reg[`SBS_CTRL_SLEEP_ACKNOWLEDGE] && !ctrl_reg[`SBS_CTRL_SOFTRST])
            mode = MODE_SLEEP;
        else if (ctrl_reg[`SBS_CTRL_SOFTRST])
            mode = MODE_SOFTRST;
        else
            mode = MODE_NORMAL;
    end
    assign coreRun = (mode == MODE_NORMAL);

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            coreClkRun <= 1'b0;
            regClkRun <= 1'b0;
        end
        else
        begin
            coreClkRun <= coreRun;
            regClkRun <= (mode != MODE_PWRSAVE);
        end
    end

    // Receive pin synchroniser
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rxMeta_reg <= 1'b1;
            rxSync_reg <= 1'b1;
            rxSyncPrev_reg <= 1'b1;
        end
        else
        begin
            rxMeta_reg <= busRx;
            rxSync_reg <= rxMeta_reg;
            rxSyncPrev_reg <= rxSync_reg;
        end
    end

    // Any falling edge counts as bus activity; the waking message itself is lost
    assign wakeEvt = ctrl_reg[`SBS_CTRL_SLEEP_ACKNOWLEDGE] && rxSyncPrev_reg && !rxSync_reg;

    // Transmit and echo path; line held recessive outside normal mode
    assign txNext = coreRun ? (!masterDrive_reg && txCore) : 1'b1;
    assign txBusy = !txNext || txActive;
    assign rxEff = (txBusy || echoCnt_reg != 8'h00) ? txNext : rxSync_reg;
    assign pls.rxLevel = coreRun ? rxEff : 1'b1;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            echoCnt_reg <= 8'h00;
            busTx <= 1'b1;
            rxCore <= 1'b1;
        end
        else
        begin
            if (txBusy)
                echoCnt_reg <= ECHO_CYC;
            else if (echoCnt_reg != 8'h00)
                echoCnt_reg <= echoCnt_reg - 8'h01;
            busTx <= txNext;
            rxCore <= rxEff;
        end
    end

    // Pulse position; start is taken at the falling edge of the pulse
    assign startPos = (cycCnt_reg > pls.pulseLen) ? cycCnt_reg - pls.pulseLen : 16'h0000;
    assign inWait = startPos < WAIT_END;
    assign validSync = coreRun && pls.pulseEnd
        && (pls.pulseClass == PLS_ALARM || pls.pulseClass == PLS_NORMAL);
    assign earlyEvt = validSync && !blocked_reg && cycCnt_reg < CMIN;
    assign formatEvt = coreRun && (frameError
        || (pls.pulseEnd && inWait && pls.pulseClass == PLS_SHORT));
    assign badEvt = coreRun && pls.pulseEnd && !validSync
        && (!inWait || pls.pulseClass != PLS_SHORT);
    assign lostEvt = coreRun && cycCnt_reg == CMAX - 16'h0001;

    // Cycle timer restarts on every valid-length sync, whatever its position
    always_ff @(posedge mclk)
    begin
        if (reset)
            cycCnt_reg <= 16'h0000;
        else if (validSync)
            cycCnt_reg <= 16'h0000;
        else if (coreRun && cycCnt_reg != CMAX)
            cycCnt_reg <= cycCnt_reg + 16'h0001;
    end

    // Transfers stay off after reset, bus-activity wake, loss or bad pulse until a sync arrives
    always_ff @(posedge mclk)
    begin
        if (reset)
            blocked_reg <= 1'b1;
        else if (wakeEvt)
            blocked_reg <= 1'b1;
        else if (validSync)
            blocked_reg <= 1'b0;
        else if (lostEvt || badEvt)
            blocked_reg <= 1'b1;
    end

    // Format errors keep sync but hold transfers off for the idle time
    always_ff @(posedge mclk)
    begin
        if (reset)
            idleCnt_reg <= 8'h00;
        else if (formatEvt)
            idleCnt_reg <= IDLE_CYC;
        else if (idleCnt_reg != 8'h00)
            idleCnt_reg <= idleCnt_reg - 8'h01;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            transferBlocked <= 1'b1;
            syncStrobe <= 1'b0;
        end
        else
        begin
            transferBlocked <= blocked_reg || idleCnt_reg != 8'h00 || !coreRun;
            syncStrobe <= validSync;
        end
    end

    // Master pulse ends at the nominal cycle; its echo then restarts the timer
    assign masterLen = ctrl_reg[`SBS_CTRL_ALARM] ? A_NOM : N_NOM;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            masterDrive_reg <= 1'b0;
            masterCnt_reg <= 16'h0000;
        end
        else if (!coreRun || !ctrl_reg[`SBS_CTRL_MASTER])
        begin
            masterDrive_reg <= 1'b0;
            masterCnt_reg <= 16'h0000;
        end
        else if (!masterDrive_reg && cycCnt_reg == CNOM - masterLen)
        begin
            // After a wake the timer resumes from its held value, so the first sync waits until it reaches CNOM - masterLen
            masterDrive_reg <= 1'b1;
            masterCnt_reg <= masterLen - 16'h0001;
        end
        else if (masterDrive_reg)
        begin
            if (masterCnt_reg == 16'h0000)
                masterDrive_reg <= 1'b0;
            else
                masterCnt_reg <= masterCnt_reg - 16'h0001;
        end
    end

    // Sleep entry once nothing is left to send or receive
    assign sleepReadyNow = !txActive && !txPending && !rxBusy && !masterDrive_reg;

    // Control register
    always_ff @(posedge mclk)
    begin
        if (reset)
            ctrl_reg <= `SBS_CTRL_RESET;
        else
        begin
            if (wrTake && avs_address == `SBS_OFS_CTRL)
            begin
                ctrl_reg[`SBS_CTRL_MASTER] <= wdata[`SBS_CTRL_MASTER];
                ctrl_reg[`SBS_CTRL_SOFTRST] <= wdata[`SBS_CTRL_SOFTRST];
                ctrl_reg[`SBS_CTRL_STOP_IN_CPU_WAIT] <= wdata[`SBS_CTRL_STOP_IN_CPU_WAIT];
                if (wdata[`SBS_CTRL_SLEEP_REQUEST] || ctrl_reg[`SBS_CTRL_SLEEP_ACKNOWLEDGE])
                    ctrl_reg[`SBS_CTRL_SLEEP_REQUEST] <= wdata[`SBS_CTRL_SLEEP_REQUEST];
                if (wdata[`SBS_CTRL_SOFTRST])
                    ctrl_reg[`SBS_CTRL_SLEEP_ACKNOWLEDGE] <= 1'b0;
            end
            if (wakeEvt)
            begin
                ctrl_reg[`SBS_CTRL_SLEEP_REQUEST] <= 1'b0;
                ctrl_reg[`SBS_CTRL_SLEEP_ACKNOWLEDGE] <= 1'b0;
            end
            else if (!ctrl_reg[`SBS_CTRL_SLEEP_REQUEST])
                ctrl_reg[`SBS_CTRL_SLEEP_ACKNOWLEDGE] <= 1'b0;
            else if (coreRun && sleepReadyNow && !ctrl_reg[`SBS_CTRL_SOFTRST])
                ctrl_reg[`SBS_CTRL_SLEEP_ACKNOWLEDGE] <= 1'b1;
            // Alarm: write one restarts the hold time, write zero drops it
            if (wrTake && avs_address == `SBS_OFS_CTRL)
                ctrl_reg[`SBS_CTRL_ALARM] <= wdata[`SBS_CTRL_ALARM];
            else if (ctrl_reg[`SBS_CTRL_ALARM] && alarmCnt_reg == ALARM_LAST)
                ctrl_reg[`SBS_CTRL_ALARM] <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            alarmCnt_reg <= 25'h000_0000;
        else if (wrTake && avs_address == `SBS_OFS_CTRL && wdata[`SBS_CTRL_ALARM])
            alarmCnt_reg <= 25'h000_0000;
        else if (ctrl_reg[`SBS_CTRL_ALARM])
            alarmCnt_reg <= alarmCnt_reg + 25'h000_0001;
        else
            alarmCnt_reg <= 25'h000_0000;
    end

    // Sticky status flags; a set in the same cycle beats the clear
    always_comb
    begin
        setVec = '0;
        setVec[`SBS_ST_ALARM_SYNC] = validSync && pls.pulseClass == PLS_ALARM;
        setVec[`SBS_ST_NORMAL_SYNC] = validSync && pls.pulseClass == PLS_NORMAL;
        setVec[`SBS_ST_FORMAT] = formatEvt;
        setVec[`SBS_ST_EARLY] = earlyEvt;
        setVec[`SBS_ST_LOST] = lostEvt;
        setVec[`SBS_ST_BADPULSE] = badEvt;
        setVec[`SBS_ST_WAKEUP] = wakeEvt;
        setVec[`SBS_ST_OVERRUN] = fifoOverrun;
        setVec[`SBS_ST_LOCK] = lockError;
        setVec[`SBS_ST_SLOT] = slotMismatch;
    end
    assign clrVec = (wrTake && avs_address == `SBS_OFS_STATUS) ? wdata[`SBS_ST_W-1:0] : '0;

    always_ff @(posedge mclk)
    begin
        if (reset)
            status_reg <= '0;
        else
            status_reg <= (status_reg & ~clrVec) | setVec;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            bufFlag_reg <= 16'h0000;
        else if (wrTake && avs_address == `SBS_OFS_BUFFLAG)
            bufFlag_reg <= (bufFlag_reg & ~wdata[15:0]) | bufSet;
        else
            bufFlag_reg <= bufFlag_reg | bufSet;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            enable_reg <= '0;
            bufEn_reg <= 16'h0000;
        end
        else
        begin
            if (wrTake && avs_address == `SBS_OFS_ENABLE)
                enable_reg <= wdata[`SBS_EN_W-1:0];
            if (wrTake && avs_address == `SBS_OFS_BUFEN)
                bufEn_reg <= wdata[15:0];
        end
    end

    // Interrupt grouping
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            irqFifo <= 1'b0;
            irqRx <= 1'b0;
            irqSync <= 1'b0;
            irqGeneral <= 1'b0;
        end
        else
        begin
            irqFifo <= fifoNotEmpty && enable_reg[`SBS_ST_FIFO];
            irqRx <= |(bufFlag_reg & bufEn_reg & ~bufIsTx);
            irqSync <= |(status_reg[`SBS_ST_NORMAL_SYNC:`SBS_ST_ALARM_SYNC]
                & enable_reg[`SBS_ST_NORMAL_SYNC:`SBS_ST_ALARM_SYNC]);
            irqGeneral <= |(bufFlag_reg & bufEn_reg & bufIsTx)
                || |(status_reg[`SBS_ST_SLOT:`SBS_ST_FORMAT]
                & enable_reg[`SBS_ST_SLOT:`SBS_ST_FORMAT]);
        end
    end

    assign avs_readdata = rdData_reg;
    assign avs_waitrequest = waitReq_reg;
endmodule
`default_nettype wire

/* verif/sbs_bus_node.sv */
// Far-side bus node that drives dominant pulses onto the receive pin.
// Assumes the block's mclk; the line idles recessive through a pull-up.
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_node (
    // Clock and command
    input wire logic mclk,
    input wire logic [15:0] lowLen,
    input wire logic go,
    // Bus line
    output logic busLine
);
    logic [15:0] cnt = 0;
    always @(posedge mclk)
    begin
        if (go)
            cnt <= lowLen;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    // A released line returns to the pull-up level, never the last driven value
    assign busLine = (cnt == 0);
endmodule
`default_nettype wire

/* verif/sbs_sync_power_checker.sv */
// Port-level assertions for the sync, error and power block.
// Assumes one mclk domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sbs_sync_power_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Watched ports
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic busTx,
    input wire logic rxCore,
    input wire logic syncStrobe,
    input wire logic coreClkRun,
    input wire logic regClkRun,
    input wire logic cpuStopped,
    input wire logic fifoNotEmpty,
    input wire logic irqFifo
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    a_bus_answer:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("late bus answer");
    a_bus_release:
        assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait stuck low");
    a_tx_quiet:
        assert property (!coreClkRun && !$past(coreClkRun) |-> busTx) else $error("tx active");
    a_clk_order:
        assert property (coreClkRun |-> regClkRun) else $error("core clock without reg clock");
    a_stop_saves:
        assert property (cpuStopped [*4] |-> !regClkRun && !coreClkRun)
        else $error("clocks run in stop");
    a_strobe_once:
        assert property (syncStrobe |=> !syncStrobe) else $error("sync strobe too long");
    a_echo_own:
        assert property (!busTx [*4] |-> !rxCore) else $error("own transmit not echoed");
    a_fifo_quiet:
        assert property (!fifoNotEmpty [*4] |-> !irqFifo) else $error("fifo request no cause");
    c_sync: cover property (syncStrobe);
    c_sleep: cover property (!coreClkRun && regClkRun);
    c_master: cover property (!busTx);
endmodule
bind sbs_sync_power sbs_sync_power_checker chk_u (.mclk(mclk), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .busTx(busTx), .rxCore(rxCore), .syncStrobe(syncStrobe), .coreClkRun(coreClkRun),
    .regClkRun(regClkRun), .cpuStopped(cpuStopped), .fifoNotEmpty(fifoNotEmpty),
    .irqFifo(irqFifo));
`default_nettype wire

/* verif/sbs_sync_power_tb.sv */
// Self-checking bench: registers, far-side pulses, sleep, wake, clocks and master pulses.
// Assumes shortened cycle counts; every expectation follows from the values set here.
`timescale 1ns/1ps
`default_nettype none
module sbs_sync_power_tb;
    logic mclk = 0, reset = 1, rd = 0, wr = 0, go = 0, rxBusy = 0, stop = 0, wt = 0;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, avs_readdata;
    logic [15:0] lowLen = 0, bufSet = 0, bufIsTx = 0;
    logic [4:0] ev = 0;
    logic txc = 1, txa = 0, txp = 0;
    logic [63:0] note, q[$];
    logic busRx, avs_waitrequest, busTx, rxCore, transferBlocked, syncStrobe;
    logic coreClkRun, regClkRun, irqFifo, irqRx, irqSync, irqGeneral;
    int errors = 0, nChecks = 0, seed = 22804, len;
    sbs_bus_node node_u (.mclk, .lowLen, .go, .busLine(busRx));
    sbs_sync_power #(.CYC_NOM(2000), .CYC_MIN(1990), .CYC_MAX(2010), .ALARM_CYC(1000),
        .BIT_CYC(13)) dut_u (.mclk, .reset, .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_readdata, .avs_waitrequest, .busRx, .busTx,
        .cpuStopped(stop), .cpuWaiting(wt), .txCore(txc), .txActive(txa),
        .txPending(txp), .rxBusy, .frameError(ev[0]), .fifoNotEmpty(ev[4]),
        .fifoOverrun(ev[1]), .lockError(ev[2]), .slotMismatch(ev[3]), .bufSet, .bufIsTx,
        .rxCore, .transferBlocked, .syncStrobe, .coreClkRun, .regClkRun, .irqFifo, .irqRx,
        .irqSync, .irqGeneral);
    initial
        forever #4 mclk = ~mclk;
    task automatic complete_run;
        if (errors == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        nChecks++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Read expectations go to the queue; the monitor judges them when data arrive
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        if (!w)
            q.push_back({d, m});
        @(posedge mclk);
        while (avs_waitrequest)
            @(posedge mclk);
        rd <= 0;
        wr <= 0;
        @(posedge mclk);
    endtask
    task automatic pulse(input int n);
        lowLen <= n[15:0];
        go <= 1;
        @(posedge mclk);
        go <= 0;
        cyc(n + 10);
    endtask
    task automatic lowRun(output int n);
        n = 0;
        while (busTx)
            @(posedge mclk);
        while (!busTx)
        begin
            @(posedge mclk);
            n++;
        end
    endtask
    always @(posedge mclk)
    begin
        if (rd && !avs_waitrequest && q.size() > 0)
        begin
            note = q.pop_front();
            chk(avs_readdata & note[31:0], note[63:32]);
        end
    end
    initial
    begin
        #(40000 * 8);
        errors++;
        complete_run();
    end
    initial
    begin
        cyc(16);
        reset <= 0;
        @(posedge mclk);
        acc(0, 8'h00, 32'h0, '1);
        acc(0, 8'h14, 32'h0, '1);
        acc(0, 8'hFC, 32'h0, '1);
        pulse(232 + {$random(seed)} % 37);
        acc(0, 8'h04, 32'h1, 32'h3FF);
        chk(transferBlocked, 1'b0);
        acc(1, 8'h04, 32'h1, 0);
        pulse(357 + {$random(seed)} % 37);
        acc(0, 8'h04, 32'hA, 32'h3FF);
        acc(1, 8'h04, 32'hA, 0);
        pulse(300);
        acc(0, 8'h04, 32'h20, 32'h3FF);
        chk(transferBlocked, 1'b1);
        acc(1, 8'h04, 32'h20, 0);
        cyc(2100);
        acc(0, 8'h04, 32'h10, 32'h3FF);
        acc(1, 8'h08, 32'h2, 0);
        pulse(375);
        chk({irqSync, transferBlocked}, 2'b10);
        acc(1, 8'h04, 32'h3FF, 0);
        cyc(2);
        chk(irqSync, 1'b0);
        {rxBusy, txp, txa} <= 3'b111;
        acc(1, 8'h00, 32'h4, 0);
        acc(1, 8'h00, 32'h0, 0);
        acc(0, 8'h00, 32'h4, '1);
        {rxBusy, txp, txa} <= 0;
        cyc(4);
        acc(0, 8'h00, 32'h24, '1);
        acc(0, 8'h14, 32'h1, '1);
        chk({coreClkRun, regClkRun, busTx}, 3'b011);
        acc(1, 8'h08, 32'h40, 0);
        pulse(40);
        chk(irqGeneral, 1'b1);
        acc(0, 8'h00, 32'h0, '1);
        acc(1, 8'h00, 32'h8, 0);
        acc(0, 8'h14, 32'h2, '1);
        chk({coreClkRun, regClkRun}, 2'b01);
        acc(1, 8'h00, 32'h10, 0);
        for (int i = 0; i < 2; i++)
        begin
            {stop, wt} <= 2'b10 >> i;
            cyc(5);
            chk({coreClkRun, regClkRun}, 2'b00);
            {stop, wt} <= 2'b00;
            cyc(5);
        end
        acc(1, 8'h04, 32'h3FF, 0);
        acc(1, 8'h08, 32'h404, 0);
        acc(1, 8'h10, 32'h8001, 0);
        bufIsTx <= 16'h8000;
        bufSet <= 16'h0001;
        {txc, ev} <= 6'h1F;
        @(posedge mclk);
        bufSet <= 0;
        {txc, ev} <= 6'h30;
        cyc(4);
        chk({irqRx, irqFifo, irqGeneral}, 3'b111);
        acc(0, 8'h04, 32'h784, 32'h7FF);
        acc(1, 8'h04, 32'h3FF, 0);
        acc(1, 8'h0C, 32'h1, 0);
        ev <= 0;
        cyc(3);
        chk({irqRx, irqFifo, irqGeneral}, 3'b000);
        pulse(375);
        acc(1, 8'h00, 32'h1, 0);
        lowRun(len);
        chk(len, 375);
        acc(1, 8'h00, 32'h3, 0);
        cyc(900);
        acc(1, 8'h00, 32'h3, 0);
        lowRun(len);
        chk(len, 250);
        acc(0, 8'h00, 32'h1, '1);
        complete_run();
    end
endmodule
`default_nettype wire
